// ### rtl/stp_defines.vh
/*
 defines for the serial to parallel converter: widths, control bits,
 slip and register map. assumes inclusion by bare name from rtl/.
*/
`ifndef STP_DEFINES_VH
`define STP_DEFINES_VH

`define STP_WORD_W        4
`define STP_DIV_W         3
`define STP_SLIP_MIN      2
`define STP_SLIP_CNT_W    2

`define STP_ADDR_CTRL     12'h000
`define STP_ADDR_STAT     12'h004
`define STP_ADDR_WORD     12'h008
`define STP_ADDR_SLIPS    12'h00C

`define STP_CTRL_SEL      0
`define STP_CTRL_MODE     1
`define STP_CTRL_SLIP     2
`define STP_CTRL_RST_VAL  32'h0000_0001

`define STP_STAT_PHASE_LO 0
`define STP_STAT_PHASE_HI 2

`endif

// ### rtl/stp_slip_det.v
/*
 bit slip detector: synchronises the slip request and emits one pulse
 per request that stayed high for the least width.
 assumes one clock mclk and async reset rst.
*/
`timescale 1ns/1ps
`include "stp_defines.vh"

module stp_slip_det #(
  parameter MIN_W = `STP_SLIP_MIN
) (
  input  wire mclk,
  input  wire rst,
  input  wire slip_in,
  output wire slip_go
);
  reg                       sync1_q;
  reg                       sync2_q;
  reg [`STP_SLIP_CNT_W-1:0] width_q;
  reg                       done_q;

  // two stage synchroniser
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= slip_in;
      sync2_q <= sync2_q ^ (sync1_q ^ sync2_q);
    end
  end

  // count the pulse width, fire once per pulse
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      width_q <= {`STP_SLIP_CNT_W{1'b0}};
      done_q  <= 1'b0;
    end else if (!sync2_q) begin
      width_q <= {`STP_SLIP_CNT_W{1'b0}};
      done_q  <= 1'b0;
    end else if (!done_q) begin
      width_q <= width_q + 1'b1;
      if (width_q == MIN_W[`STP_SLIP_CNT_W-1:0] - 2'h1)
        done_q <= 1'b1;
    end
  end

  assign slip_go = sync2_q && !done_q &&
                   (width_q == MIN_W[`STP_SLIP_CNT_W-1:0] - 2'h1);
endmodule

// ### rtl/stp_shifter.v
/*
 serial shift path: picks the serial input and shifts bits in arrival
 order so the oldest bit of the word sits at bit 0.
 assumes one clock mclk and async reset rst.
*/
`timescale 1ns/1ps
`include "stp_defines.vh"

module stp_shifter #(
  parameter WORD_W = `STP_WORD_W
) (
  input  wire              mclk,
  input  wire              rst,
  input  wire              serial_in_a,
  input  wire              serial_in_b,
  input  wire              src_sel,
  output wire [WORD_W-1:0] shift_word
);
  reg  [WORD_W-1:0] shift_q;
  wire              bit_in;

  assign bit_in = src_sel ? serial_in_a : serial_in_b;

  // new bit enters at the top, older bits move toward bit 0
  always @(posedge mclk or posedge rst) begin
    if (rst)
      shift_q <= {WORD_W{1'b0}};
    else
      shift_q <= {bit_in, shift_q[WORD_W-1:1]};
  end

  // word as it stands after this edge, so the load edge's bit is kept
  assign shift_word = {bit_in, shift_q[WORD_W-1:1]};
endmodule

// ### rtl/stp_converter.v
/*
 serial to parallel converter top: shift path, divide by 4 and 8 clocks,
 bit slip, 4 bit word loaded every 4 or 8 clocks and an apb register slave.
 assumes serial data and all pins synchronous to mclk, async reset rst.
*/
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "stp_defines.vh"

module stp_converter #(
  parameter WORD_W = `STP_WORD_W
) (
  input  wire              mclk,
  input  wire              rst,
  input  wire              serial_in_a,
  input  wire              serial_in_b,
  input  wire              src_sel,
  input  wire              conv_mode,
  input  wire              bit_slip_pulse,
  input  wire              global_clear,
  output reg  [WORD_W-1:0] parallel_out,
  output wire              quarter_rate_clock,
  output wire              quarter_rate_clock_n,
  output wire              eighth_rate_clock,
  output wire              eighth_rate_clock_n,
  output wire              word_strobe,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr
);
  localparam [`STP_DIV_W-1:0] PH_ZERO = 3'h0;
  localparam [`STP_DIV_W-1:0] PH_LAST = 3'h7;

  reg  [31:0]            ctrl_q;
  reg  [`STP_DIV_W-1:0]  phase_q;
  reg  [`STP_DIV_W-1:0]  phase_d;
  reg  [15:0]            slips_q;
  reg                    q4_q;
  reg                    q8_q;
  reg                    strobe_q;
  wire [WORD_W-1:0]      shift_word;
  wire                   slip_go;
  wire                   use_sel;
  wire                   use_mode;
  wire                   slip_req;
  wire                   clr;
  wire                   wr_en;
  wire                   load;

  function hit;
    input [11:0] a;
    input [11:0] ref_a;
    begin
      hit = (a == ref_a);
    end
  endfunction

  // pins or control register steer the datapath
  assign use_sel  = src_sel | ctrl_q[`STP_CTRL_SEL];
  assign use_mode = conv_mode | ctrl_q[`STP_CTRL_MODE];
  assign slip_req = bit_slip_pulse | ctrl_q[`STP_CTRL_SLIP];
  assign clr      = global_clear;

  stp_shifter #(
    .WORD_W      (WORD_W)
  ) u_shift (
    .mclk        (mclk),
    .rst         (rst),
    .serial_in_a (serial_in_a),
    .serial_in_b (serial_in_b),
    .src_sel     (use_sel),
    .shift_word  (shift_word)
  );

  stp_slip_det #(
    .MIN_W   (`STP_SLIP_MIN)
  ) u_slip (
    .mclk    (mclk),
    .rst     (rst),
    .slip_in (slip_req),
    .slip_go (slip_go)
  );

  // divider phase; a slip holds the phase for one clock
  always @* begin
    if (clr)
      phase_d = PH_ZERO;
    else if (slip_go)
      phase_d = phase_q;
    else
      phase_d = phase_q + 3'h1;
  end

  always @(posedge mclk or posedge rst) begin
    if (rst)
      phase_q <= PH_ZERO;
    else
      phase_q <= phase_d;
  end

  // divided clocks from phase bits
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      q4_q <= 1'b0;
      q8_q <= 1'b0;
    end else begin
      q4_q <= phase_d[1];
      q8_q <= phase_d[2];
    end
  end

  assign quarter_rate_clock   = q4_q;
  assign quarter_rate_clock_n = ~q4_q;
  assign eighth_rate_clock    = q8_q;
  assign eighth_rate_clock_n  = ~q8_q;

  // word complete at end of the divider cycle
  assign load = !clr && !slip_go &&
                (use_mode ? (phase_q == PH_LAST)
                          : (phase_q[1:0] == 2'h3));

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      parallel_out <= {WORD_W{1'b0}};
      strobe_q     <= 1'b0;
    end else begin
      strobe_q <= load;
      if (clr)
        parallel_out <= {WORD_W{1'b0}};
      else if (load)
        parallel_out <= shift_word;
    end
  end

  assign word_strobe = strobe_q;

  // apb slave, zero wait
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;

  always @(posedge mclk or posedge rst) begin
    if (rst)
      ctrl_q <= `STP_CTRL_RST_VAL;
    else if (wr_en && hit(paddr, `STP_ADDR_CTRL))
      ctrl_q <= {29'h0, pwdata[2:0]};
  end

  // slip counter, cleared by write
  always @(posedge mclk or posedge rst) begin
    if (rst)
      slips_q <= 16'h0000;
    else if (slip_go)
      slips_q <= slips_q + 16'h0001;
    else if (wr_en && hit(paddr, `STP_ADDR_SLIPS))
      slips_q <= 16'h0000;
  end

  always @(posedge mclk or posedge rst) begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      if (hit(paddr, `STP_ADDR_CTRL))
        prdata <= ctrl_q;
      else if (hit(paddr, `STP_ADDR_STAT))
        prdata <= {26'h0, q8_q, q4_q, use_mode, phase_q};
      else if (hit(paddr, `STP_ADDR_WORD))
        prdata <= {{(32-WORD_W){1'b0}}, parallel_out};
      else if (hit(paddr, `STP_ADDR_SLIPS))
        prdata <= {16'h0000, slips_q};
      else
        prdata <= 32'h0000_0000;
    end
  end
endmodule

// ### dv/stp_ser_src.sv
/* serial source model for the converter's far side.
   one bit per mclk, bit 0 first; restarts when clr is high. */
`timescale 1ns/1ps
module stp_ser_src (
  input  wire       mclk,
  input  wire       clr,
  input  wire [7:0] word_a,
  input  wire [7:0] word_b,
  output wire       serial_in_a,
  output wire       serial_in_b
);
  reg [2:0] idx_q;
  always @(posedge mclk) begin
    idx_q <= clr ? 3'h0 : idx_q + 3'h1;
  end
  assign serial_in_a = word_a[idx_q];
  assign serial_in_b = word_b[idx_q];
endmodule

// ### dv/stp_conv_sva.sv
/* port checker for stp_converter.
   bound to the top; one clock mclk, async reset rst. */
`timescale 1ns/1ps
module stp_conv_sva #(
  parameter WORD_W = 4
) (
  input wire              mclk,
  input wire              rst,
  input wire              serial_in_a,
  input wire              src_sel,
  input wire              conv_mode,
  input wire              bit_slip_pulse,
  input wire              global_clear,
  input wire [WORD_W-1:0] parallel_out,
  input wire              quarter_rate_clock,
  input wire              quarter_rate_clock_n,
  input wire              eighth_rate_clock,
  input wire              eighth_rate_clock_n,
  input wire              word_strobe,
  input wire              psel,
  input wire              penable,
  input wire              pready,
  input wire              pslverr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  q4_pair_a: assert property (quarter_rate_clock_n == !quarter_rate_clock)
    else $error("q4 pair");
  q8_pair_a: assert property (eighth_rate_clock_n == !eighth_rate_clock)
    else $error("q8 pair");
  gap_four_a: assert property (word_strobe |=> !word_strobe [*3])
    else $error("gap4");
  gap_eight_a: assert property (word_strobe && conv_mode && $past(conv_mode, 8)
    |=> !word_strobe [*7]) else $error("gap8");
  clr_vals_a: assert property (global_clear |=> parallel_out == '0 && !word_strobe
    && !quarter_rate_clock && !eighth_rate_clock) else $error("clear");
  clr_first_a: assert property ($fell(global_clear) && !conv_mode
    |-> !word_strobe [*4] ##1 word_strobe) else $error("clear first");
  word_order_a: assert property (word_strobe && src_sel && $past(src_sel, 4)
    |-> parallel_out == {$past(serial_in_a, 1), $past(serial_in_a, 2),
    $past(serial_in_a, 3), $past(serial_in_a, 4)}) else $error("order");
  apb_zero_wait_a: assert property (psel && penable |-> pready && !pslverr)
    else $error("apb");
  cover property (word_strobe && conv_mode);
  cover property (global_clear);
  cover property ($rose(bit_slip_pulse));
endmodule
bind stp_converter stp_conv_sva #(.WORD_W(WORD_W)) u_stp_conv_sva (.mclk, .rst,
  .serial_in_a, .src_sel, .conv_mode, .bit_slip_pulse, .global_clear, .parallel_out,
  .quarter_rate_clock, .quarter_rate_clock_n, .eighth_rate_clock, .eighth_rate_clock_n,
  .word_strobe, .psel, .penable, .pready, .pslverr);

// ### dv/tb_top.sv
/* bench for stp_converter with a serial source model.
   apb tasks, one clock at 100 MHz, reset held 3 cycles. */
`timescale 1ns/1ps
`include "stp_defines.vh"
module tb_top;
  logic        mclk = 0, rst = 1, src_sel = 1, conv_mode = 0;
  logic        bit_slip_pulse = 0, global_clear = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0]  word_a = 8'hC1, word_b = 8'h77;
  logic [3:0]  parallel_out;
  wire         serial_in_a, serial_in_b, pready, pslverr, word_strobe;
  wire         quarter_rate_clock, eighth_rate_clock;
  int          fails = 0, cmp_count = 0, gap;
  always #5 mclk = ~mclk;
  stp_ser_src u_stp_ser_src (.mclk, .clr(rst | global_clear), .word_a, .word_b,
    .serial_in_a, .serial_in_b);
  stp_converter u_stp_converter (.mclk, .rst, .serial_in_a, .serial_in_b, .src_sel,
    .conv_mode, .bit_slip_pulse, .global_clear, .parallel_out, .quarter_rate_clock,
    .quarter_rate_clock_n(), .eighth_rate_clock, .eighth_rate_clock_n(), .word_strobe,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge mclk); i++; end while (pready !== 1'b1 && i < 16);
    rd = prdata;
    if (pready !== 1'b1) begin fails++; tally_and_finish(); end
    {psel, penable} <= 2'b00;
  endtask
  task automatic wait_strobe;
    gap = 0;
    do begin @(posedge mclk); #1; gap++; end while (word_strobe !== 1'b1 && gap < 40);
    if (word_strobe !== 1'b1) begin fails++; tally_and_finish(); end
    chk("q4 at word", quarter_rate_clock, 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 0;
    apb(0, `STP_ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h1);
    apb(0, 12'h010, 0);
    chk("unmapped", rd, 32'h0);
    @(posedge mclk) global_clear <= 1;
    @(posedge mclk) global_clear <= 0;
    #1 chk("clear", parallel_out, 0);
    wait_strobe;
    chk("first gap", gap, 4);
    chk("word lo", parallel_out, 4'h1);
    chk("q8 at word lo", eighth_rate_clock, 1'b1);
    wait_strobe;
    chk("word hi", parallel_out, 4'hC);
    chk("gap4", gap, 4);
    apb(1, `STP_ADDR_CTRL, 0);
    @(posedge mclk) src_sel <= 0;
    repeat (2) wait_strobe;
    chk("input b", parallel_out, 4'h7);
    @(posedge mclk) {conv_mode, word_b} <= {1'b1, 8'h5A};
    repeat (2) wait_strobe;
    chk("gap8", gap, 8);
    chk("word8", parallel_out, 4'h5);
    chk("q8 at word8", eighth_rate_clock, 1'b0);
    repeat (4) @(posedge mclk);
    {conv_mode, src_sel, word_a} <= {2'b01, 8'h11};
    apb(1, `STP_ADDR_SLIPS, 0);
    for (int k = 1; k < 3; k++) begin
      @(posedge mclk) bit_slip_pulse <= 1;
      repeat (3) @(posedge mclk);
      bit_slip_pulse <= 0;
      repeat (3) wait_strobe;
      chk("slip", parallel_out, 32'h1 << (4 - k));
    end
    apb(0, `STP_ADDR_SLIPS, 0);
    chk("slips", rd, 32'h2);
    tally_and_finish();
  end
  initial begin
    #200000 fails++;
    tally_and_finish();
  end
endmodule
